// >>> fsq_pkg.sv
package fsq_pkg;
  // register word offsets on the plain register port (byte address = index * 4)
  localparam logic [7:0] FSQ_REG_CTRL     = 8'h00;  // seek control / start
  localparam logic [7:0] FSQ_REG_BAND_LO  = 8'h04;  // lower band edge, channel index
  localparam logic [7:0] FSQ_REG_BAND_HI  = 8'h08;  // upper band edge, channel index
  localparam logic [7:0] FSQ_REG_CHAN     = 8'h0c;  // current / start channel
  localparam logic [7:0] FSQ_REG_RSSI_TH  = 8'h10;  // strength threshold
  localparam logic [7:0] FSQ_REG_SNR_TH   = 8'h14;  // snr threshold
  localparam logic [7:0] FSQ_REG_OFS_TH   = 8'h18;  // offset magnitude limit
  localparam logic [7:0] FSQ_REG_RSSI_QT  = 8'h1c;  // strength qualification time
  localparam logic [7:0] FSQ_REG_SNR_QT   = 8'h20;  // snr qualification time
  localparam logic [7:0] FSQ_REG_STATUS   = 8'h24;  // busy, result flags
  localparam logic [7:0] FSQ_REG_METRICS  = 8'h28;  // live rssi/snr/ofs
  localparam logic [7:0] FSQ_REG_IRQ_STAT = 8'h2c;  // sticky events, write one to clear
  localparam logic [7:0] FSQ_REG_IRQ_MASK = 8'h30;  // interrupt enable mask

  // control register fields
  localparam int FSQ_CTRL_START = 0;  // write one: band_search_begin_cmd
  localparam int FSQ_CTRL_UP    = 1;  // direction, one = upward
  localparam int FSQ_CTRL_WRAP  = 2;  // wrap at band edge
  localparam int FSQ_CTRL_DDET  = 3;  // fast digital detect engaged
  localparam int FSQ_CTRL_OFSEN = 4;  // offset check engaged
  localparam int FSQ_CTRL_TUNE  = 5;  // write one: qualify current channel only

  // interrupt status fields
  localparam int FSQ_IRQ_DONE  = 0;
  localparam int FSQ_IRQ_FOUND = 1;
  localparam int FSQ_IRQ_NW    = 2;

  localparam int FSQ_CHW = 10;  // channel index width
  localparam int FSQ_MW  = 8;   // metric width
  localparam int FSQ_QTW = 12;  // qualification time, in tick units

  // settle time after each retune before metrics are looked at
  localparam int FSQ_SETTLE_US  = 1;
  localparam int FSQ_CLK_MHZ    = 100;
  localparam int FSQ_SETTLE_CYC = FSQ_SETTLE_US * FSQ_CLK_MHZ;
  // qualification time unit: one tick per microsecond
  localparam int FSQ_TICK_CYC   = FSQ_CLK_MHZ;

  localparam logic [FSQ_CHW-1:0] FSQ_BAND_LO_RST = 10'h000;
  localparam logic [FSQ_CHW-1:0] FSQ_BAND_HI_RST = 10'h0cc;
  localparam logic [FSQ_MW-1:0]  FSQ_RSSI_TH_RST = 8'h14;
  localparam logic [FSQ_MW-1:0]  FSQ_SNR_TH_RST  = 8'h0a;
  localparam logic [FSQ_MW-1:0]  FSQ_OFS_TH_RST  = 8'h0a;
  localparam logic [FSQ_QTW-1:0] FSQ_QT_RST      = 12'h00a;

  typedef enum logic [2:0] {
    FSQ_IDLE   = 3'b000,
    FSQ_STEP   = 3'b001,
    FSQ_SETTLE = 3'b011,
    FSQ_RSSI   = 3'b111,
    FSQ_SNR    = 3'b110,
    FSQ_DONE   = 3'b100
  } fsq_state_e;
endpackage : fsq_pkg

// >>> fsq_tick_if.sv
`timescale 1ns/1ps
// tick divider signals shared between the seek core and its divider
interface fsq_tick_if;
  logic clr;   // restart the divider phase
  logic tick;  // one-cycle pulse per qualification unit
  modport ctl (output clr, input tick);
  modport div (input clr, output tick);
endinterface : fsq_tick_if

// >>> fsq_tick_div.sv
`timescale 1ns/1ps
// divides the core clock into a qualification-time tick
module fsq_tick_div
  import fsq_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  fsq_tick_if.div   tk
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } fsq_div_s;

  fsq_div_s cur_ff;
  fsq_div_s nxt_ff;

  // restart on clear so each check times a whole unit from its start
  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.tick = 1'b0;
    if (tk.clr || cur_ff.cnt == 8'(FSQ_TICK_CYC - 1))
    begin
      nxt_ff.cnt = 8'h00;
      nxt_ff.tick = !tk.clr;
    end
    else
    begin
      nxt_ff.cnt = cur_ff.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      cur_ff <= '0;
    else
      cur_ff <= nxt_ff;
  end

  assign tk.tick = cur_ff.tick;
endmodule : fsq_tick_div

// >>> fsq_seek.sv
`timescale 1ns/1ps
module fsq_seek
  import fsq_pkg::*;
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [7:0]           addr_in,
  input  wire logic [31:0]          wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [31:0]          rdata_out,
  input  wire logic [fsq_pkg::FSQ_MW-1:0] rssi_in,
  input  wire logic [fsq_pkg::FSQ_MW-1:0] snr_in,
  input  wire logic signed [fsq_pkg::FSQ_MW-1:0] ofs_in,
  input  wire logic                 ddet_in,
  input  wire logic                 guide_present_in,
  output logic [fsq_pkg::FSQ_CHW-1:0] tune_chan_out,
  output logic                      tune_req_out,
  output logic                      irq_out
);
  // whole block state; one copy computed, one copy registered
  typedef struct packed {
    fsq_state_e          st;
    logic                up;
    logic                wrap;
    logic                ddet_en;
    logic                ofs_en;
    logic                tune_only;
    logic [FSQ_CHW-1:0]  band_lo;
    logic [FSQ_CHW-1:0]  band_hi;
    logic [FSQ_CHW-1:0]  chan;
    logic [FSQ_CHW-1:0]  start;
    logic [FSQ_MW-1:0]   rssi_th;
    logic [FSQ_MW-1:0]   snr_th;
    logic [FSQ_MW-1:0]   ofs_th;
    logic [FSQ_QTW-1:0]  rssi_qt;
    logic [FSQ_QTW-1:0]  snr_qt;
    logic [FSQ_QTW-1:0]  qcnt;
    logic [7:0]          settle;
    logic                found;
    logic                ddet_seen;
    logic                guide_seen;
    logic [FSQ_MW-1:0]   m_rssi;
    logic [FSQ_MW-1:0]   m_snr;
    logic [FSQ_MW-1:0]   m_ofs;
    logic [2:0]          irq_stat;
    logic [2:0]          irq_mask;
    logic [31:0]         rdata;
    logic                tune_req;
    logic                irq;
  } fsq_state_s;

  fsq_state_s  cur_ff;
  fsq_state_s  nxt_ff;
  fsq_tick_if  tk ();
  // divider restart request from the sequencer
  logic        tk_clr;

  // qualification tick; cleared at each check start so windows are whole units
  fsq_tick_div u_div (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .tk         (tk)
  );

  // the core drives the clear through the shared interface
  assign tk.clr = tk_clr;

  // magnitude of the most negative offset still fits unsigned
  logic [FSQ_MW-1:0] ofs_mag;
  logic              rssi_ok;
  logic              snr_ok;
  logic              at_stop;
  logic [FSQ_CHW-1:0] next_chan;
  // events raised this cycle, in interrupt status layout
  logic [2:0]        ev;

  // metric inputs are taken as already synchronous to the core clock
  // metric comparisons against programmed limits
  always_comb
  begin
    ofs_mag = ofs_in[FSQ_MW-1] ? FSQ_MW'(-ofs_in) : ofs_in;
    rssi_ok = rssi_in >= cur_ff.rssi_th;
    snr_ok  = (snr_in >= cur_ff.snr_th)
            && (!cur_ff.ofs_en || ofs_mag <= cur_ff.ofs_th)
            && (!cur_ff.ddet_en || ddet_in);
  end

  // next candidate and stop frequency detection
  always_comb
  begin
    next_chan = cur_ff.chan;
    at_stop   = 1'b0;
    if (cur_ff.up)
    begin
      // upward: the top edge rolls over to the bottom edge
      if (cur_ff.chan >= cur_ff.band_hi)
      begin
        next_chan = cur_ff.band_lo;
        at_stop   = !cur_ff.wrap;
      end
      else
        next_chan = cur_ff.chan + 10'h001;
    end
    else
    begin
      // downward mirrors the upward case
      if (cur_ff.chan <= cur_ff.band_lo)
      begin
        next_chan = cur_ff.band_hi;
        at_stop   = !cur_ff.wrap;
      end
      else
        next_chan = cur_ff.chan - 10'h001;
    end
    // wrapping ends before the step that would return to the departure channel
    if (cur_ff.wrap && next_chan == cur_ff.start)
      at_stop = 1'b1;
  end

  // main seek sequencer and register file
  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.tune_req = 1'b0;
    ev = 3'h0;
    tk_clr = 1'b0;
    case (cur_ff.st)
      FSQ_IDLE:
      begin
        // waits for a start or tune write below
      end
      FSQ_SETTLE:
      begin
        // metrics are meaningless until the synthesizer settles
        if (cur_ff.settle == 8'(FSQ_SETTLE_CYC - 1))
        begin
          nxt_ff.st = FSQ_RSSI;
          nxt_ff.qcnt = '0;
          tk_clr = 1'b1;
        end
        else
          nxt_ff.settle = cur_ff.settle + 8'h01;
      end
      FSQ_RSSI:
      begin
        // strength screens every candidate first
        if (!rssi_ok)
          nxt_ff.st = FSQ_STEP;
        else if (tk.tick)
        begin
          // a zero time still waits one whole tick
          if (cur_ff.qcnt + 12'h001 >= cur_ff.rssi_qt)
          begin
            nxt_ff.st = FSQ_SNR;
            nxt_ff.qcnt = '0;
            tk_clr = 1'b1;
          end
          else
            nxt_ff.qcnt = cur_ff.qcnt + 12'h001;
        end
      end
      FSQ_SNR:
      begin
        // snr and offset only on strength-qualified candidates
        // strength must also hold through the snr window
        if (!snr_ok || !rssi_ok)
          nxt_ff.st = FSQ_STEP;
        else if (tk.tick)
        begin
          if (cur_ff.qcnt + 12'h001 >= cur_ff.snr_qt)
          begin
            nxt_ff.st = FSQ_DONE;
            nxt_ff.found = 1'b1;
            nxt_ff.ddet_seen = cur_ff.ddet_en && ddet_in;
            nxt_ff.guide_seen = cur_ff.ddet_en && ddet_in && guide_present_in;
          end
          else
            nxt_ff.qcnt = cur_ff.qcnt + 12'h001;
        end
      end
      FSQ_STEP:
      begin
        // a tune qualifies one channel only; a seek moves on
        if (cur_ff.tune_only || at_stop)
          nxt_ff.st = FSQ_DONE;
        else
        begin
          nxt_ff.chan = next_chan;
          nxt_ff.tune_req = 1'b1;
          nxt_ff.settle = '0;
          nxt_ff.st = FSQ_SETTLE;
        end
      end
      FSQ_DONE:
      begin
        // one cycle here, so each finish raises each event once
        ev[FSQ_IRQ_DONE] = 1'b1;
        ev[FSQ_IRQ_FOUND] = cur_ff.found;
        ev[FSQ_IRQ_NW] = !cur_ff.found;
        nxt_ff.st = FSQ_IDLE;
      end
      default:
        nxt_ff.st = FSQ_IDLE;
    endcase

    // live metrics, refreshed every cycle while qualifying
    // held afterwards so software still sees the last candidate
    if (cur_ff.st == FSQ_RSSI || cur_ff.st == FSQ_SNR)
    begin
      nxt_ff.m_rssi = rssi_in;
      nxt_ff.m_snr = snr_in;
      nxt_ff.m_ofs = ofs_in;
    end

    // register writes; a start while busy is ignored
    if (wr_in)
    begin
      case (addr_in)
        FSQ_REG_CTRL:
        begin
          // mode bits follow every write; only an idle sequencer takes a start
          nxt_ff.up = wdata_in[FSQ_CTRL_UP];
          nxt_ff.wrap = wdata_in[FSQ_CTRL_WRAP];
          nxt_ff.ddet_en = wdata_in[FSQ_CTRL_DDET];
          nxt_ff.ofs_en = wdata_in[FSQ_CTRL_OFSEN];
          if (cur_ff.st == FSQ_IDLE
              && (wdata_in[FSQ_CTRL_START] || wdata_in[FSQ_CTRL_TUNE]))
          begin
            nxt_ff.tune_only = wdata_in[FSQ_CTRL_TUNE] && !wdata_in[FSQ_CTRL_START];
            nxt_ff.start = cur_ff.chan;
            nxt_ff.found = 1'b0;
            nxt_ff.ddet_seen = 1'b0;
            nxt_ff.guide_seen = 1'b0;
            nxt_ff.settle = '0;
            nxt_ff.tune_req = 1'b1;
            nxt_ff.st = FSQ_SETTLE;
            // a seek begins one step away from the departure channel
            // and retunes only there, so the departure channel is not retried
            if (wdata_in[FSQ_CTRL_START])
            begin
              nxt_ff.tune_req = 1'b0;
              nxt_ff.st = FSQ_STEP;
            end
          end
        end
        FSQ_REG_BAND_LO: nxt_ff.band_lo = wdata_in[FSQ_CHW-1:0];
        FSQ_REG_BAND_HI: nxt_ff.band_hi = wdata_in[FSQ_CHW-1:0];
        FSQ_REG_CHAN:
        begin
          // retuning under a running seek would corrupt the stop test
          if (cur_ff.st == FSQ_IDLE)
            nxt_ff.chan = wdata_in[FSQ_CHW-1:0];
        end
        FSQ_REG_RSSI_TH: nxt_ff.rssi_th = wdata_in[FSQ_MW-1:0];
        FSQ_REG_SNR_TH:  nxt_ff.snr_th = wdata_in[FSQ_MW-1:0];
        FSQ_REG_OFS_TH:  nxt_ff.ofs_th = wdata_in[FSQ_MW-1:0];
        FSQ_REG_RSSI_QT: nxt_ff.rssi_qt = wdata_in[FSQ_QTW-1:0];
        FSQ_REG_SNR_QT:  nxt_ff.snr_qt = wdata_in[FSQ_QTW-1:0];
        FSQ_REG_IRQ_MASK: nxt_ff.irq_mask = wdata_in[2:0];
        default:
        begin
        end
      endcase
    end

    // write one clears, but a same-cycle event wins
    // interrupt follows the next-state copy, so it rises with the status bit
    if (wr_in && addr_in == FSQ_REG_IRQ_STAT)
      nxt_ff.irq_stat = cur_ff.irq_stat & ~wdata_in[2:0];
    nxt_ff.irq_stat = nxt_ff.irq_stat | ev;
    nxt_ff.irq = |(nxt_ff.irq_stat & nxt_ff.irq_mask);

    // read data valid only the cycle after the strobe
    // state field lets software watch the sequencer step
    nxt_ff.rdata = '0;
    if (rd_in)
    begin
      case (addr_in)
        FSQ_REG_CTRL:     nxt_ff.rdata = {26'h0, cur_ff.tune_only, cur_ff.ofs_en,
                                          cur_ff.ddet_en, cur_ff.wrap, cur_ff.up, 1'b0};
        FSQ_REG_BAND_LO:  nxt_ff.rdata = {22'h0, cur_ff.band_lo};
        FSQ_REG_BAND_HI:  nxt_ff.rdata = {22'h0, cur_ff.band_hi};
        FSQ_REG_CHAN:     nxt_ff.rdata = {22'h0, cur_ff.chan};
        FSQ_REG_RSSI_TH:  nxt_ff.rdata = {24'h0, cur_ff.rssi_th};
        FSQ_REG_SNR_TH:   nxt_ff.rdata = {24'h0, cur_ff.snr_th};
        FSQ_REG_OFS_TH:   nxt_ff.rdata = {24'h0, cur_ff.ofs_th};
        FSQ_REG_RSSI_QT:  nxt_ff.rdata = {20'h0, cur_ff.rssi_qt};
        FSQ_REG_SNR_QT:   nxt_ff.rdata = {20'h0, cur_ff.snr_qt};
        FSQ_REG_STATUS:   nxt_ff.rdata = {25'h0, cur_ff.st, cur_ff.guide_seen,
                                          cur_ff.ddet_seen, cur_ff.found,
                                          cur_ff.st != FSQ_IDLE};
        FSQ_REG_METRICS:  nxt_ff.rdata = {8'h0, cur_ff.m_ofs, cur_ff.m_snr, cur_ff.m_rssi};
        FSQ_REG_IRQ_STAT: nxt_ff.rdata = {29'h0, cur_ff.irq_stat};
        FSQ_REG_IRQ_MASK: nxt_ff.rdata = {29'h0, cur_ff.irq_mask};
        default:          nxt_ff.rdata = '0;
      endcase
    end
  end

  // single state register; sync reset to defined defaults
  // thresholds and times come up usable so a bare start works
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      cur_ff <= '0;
      cur_ff.st <= FSQ_IDLE;
      cur_ff.up <= 1'b1;
      cur_ff.band_lo <= FSQ_BAND_LO_RST;
      cur_ff.band_hi <= FSQ_BAND_HI_RST;
      cur_ff.chan <= FSQ_BAND_LO_RST;
      cur_ff.rssi_th <= FSQ_RSSI_TH_RST;
      cur_ff.snr_th <= FSQ_SNR_TH_RST;
      cur_ff.ofs_th <= FSQ_OFS_TH_RST;
      cur_ff.rssi_qt <= FSQ_QT_RST;
      cur_ff.snr_qt <= FSQ_QT_RST;
    end
    else
      cur_ff <= nxt_ff;
  end

  // every output comes straight from the state register
  assign rdata_out = cur_ff.rdata;
  assign tune_chan_out = cur_ff.chan;
  assign tune_req_out = cur_ff.tune_req;
  assign irq_out = cur_ff.irq;
endmodule : fsq_seek

// >>> fsq_seek_assertions.sv
`timescale 1ns/1ps
// watches the seek block from its ports only
module fsq_seek_assertions
  import fsq_pkg::*;
(
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic [7:0]               addr_in,
  input  wire logic [31:0]              wdata_in,
  input  wire logic                     wr_in,
  input  wire logic                     rd_in,
  input  wire logic [31:0]              rdata_out,
  input  wire logic [FSQ_MW-1:0]        rssi_in,
  input  wire logic [FSQ_MW-1:0]        snr_in,
  input  wire logic signed [FSQ_MW-1:0] ofs_in,
  input  wire logic                     ddet_in,
  input  wire logic                     guide_present_in,
  input  wire logic [FSQ_CHW-1:0]       tune_chan_out,
  input  wire logic                     tune_req_out,
  input  wire logic                     irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // begin command, then the first retune two edges later
  sequence start_cmd_s;
    wr_in && addr_in == FSQ_REG_CTRL && wdata_in[FSQ_CTRL_START];
  endsequence
  sequence retune_s;
    ##2 tune_req_out;
  endsequence
  rdata_idle_a: assert property (!rd_in |=> rdata_out == 32'h0)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (rd_in && addr_in > FSQ_REG_IRQ_MASK |=> rdata_out == 32'h0)
    else $error("unmapped read returned data");
  start_reads0_a: assert property (rd_in && addr_in == FSQ_REG_CTRL |=> !rdata_out[FSQ_CTRL_START])
    else $error("start bit reads back as one");
  pulse_gap_a: assert property (tune_req_out |=> !tune_req_out [*8])
    else $error("retune pulses too close");
  chan_move_a: assert property ($changed(tune_chan_out) |-> tune_req_out || $past(wr_in))
    else $error("channel moved without a retune");
  start_retune_a: assert property (start_cmd_s |-> retune_s)
    else $error("begin command gave no retune");
  mask_off_a: assert property (wr_in && addr_in == FSQ_REG_IRQ_MASK && wdata_in[2:0] == 3'h0
    |=> !irq_out)
    else $error("masked interrupt still high");
  reset_state_a: assert property ($rose(rst_n_in) |-> tune_chan_out == 10'h0 && !irq_out)
    else $error("outputs not at reset values");
endmodule : fsq_seek_assertions

bind fsq_seek fsq_seek_assertions u_chk (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rssi_in(rssi_in), .snr_in(snr_in),
  .ofs_in(ofs_in), .ddet_in(ddet_in), .guide_present_in(guide_present_in),
  .tune_chan_out(tune_chan_out), .tune_req_out(tune_req_out), .irq_out(irq_out)
);

// >>> fsq_tuner_model.sv
`timescale 1ns/1ps
// front end: fixed station table, metrics follow the last retune
module fsq_tuner_model (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [9:0]        chan_in,
  input  wire logic              req_in,
  output logic      [7:0]        rssi_out,
  output logic      [7:0]        snr_out,
  output logic signed [7:0]      ofs_out,
  output logic                   ddet_out,
  output logic                   guide_out
);
  logic [9:0] cur_ff;
  logic [9:0] age_ff;
  // age since retune, saturating so a long idle never wraps
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      cur_ff <= 10'h000;
      age_ff <= 10'h000;
    end
    else if (req_in)
    begin
      cur_ff <= chan_in;
      age_ff <= 10'h000;
    end
    else if (age_ff != 10'h3ff)
      age_ff <= age_ff + 10'h001;
  end
  // 3 clean, 4 digital but off-centre, 5 weak, 6 fades mid-check
  always_comb
  begin
    {rssi_out, snr_out, ofs_out, ddet_out, guide_out} = {8'h00, 8'h00, 8'sh00, 1'b0, 1'b0};
    case (cur_ff)
      10'h003: {rssi_out, snr_out, ofs_out} = {8'h28, 8'h1e, 8'sh02};
      10'h004: {rssi_out, snr_out, ofs_out, ddet_out, guide_out} = {8'h28, 8'h1e, 8'sh28, 2'b11};
      10'h005: {rssi_out, snr_out} = {8'h05, 8'h1e};
      10'h006: {rssi_out, snr_out} = {(age_ff < 10'd250) ? 8'h28 : 8'h05, 8'h1e};
      default: ;
    endcase
  end
endmodule : fsq_tuner_model

// >>> fsq_seek_test.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module fsq_seek_test;
  import fsq_pkg::*;
  logic              sys_clk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  logic [7:0]        addr_in = 8'h00;
  logic [31:0]       wdata_in = 32'h0;
  logic              wr_in = 1'b0;
  logic              rd_in = 1'b0;
  logic [31:0]       rdata_out;
  logic [7:0]        rssi_in;
  logic [7:0]        snr_in;
  logic signed [7:0] ofs_in;
  logic              ddet_in;
  logic              guide_present_in;
  logic [9:0]        tune_chan_out;
  logic              tune_req_out;
  logic              irq_out;
  logic [31:0]       d;
  int                checks = 0;
  int                n_fail = 0;
  int                cyc = 0;
  int                n_req = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  fsq_seek dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .rssi_in(rssi_in), .snr_in(snr_in), .ofs_in(ofs_in), .ddet_in(ddet_in),
    .guide_present_in(guide_present_in), .tune_chan_out(tune_chan_out),
    .tune_req_out(tune_req_out), .irq_out(irq_out));
  fsq_tuner_model u_fe (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .chan_in(tune_chan_out),
    .req_in(tune_req_out), .rssi_out(rssi_in), .snr_out(snr_in), .ofs_out(ofs_in),
    .ddet_out(ddet_in), .guide_out(guide_present_in));
  task summarize;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  // hang guard: a full run needs well under half of this
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (tune_req_out)
      n_req++;
    if (cyc == 60000)
    begin
      n_fail++;
      summarize();
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    v = rdata_out;
  endtask : rd
  task run_seek(input logic [9:0] ch, input logic [31:0] ctl, input logic [9:0] ech,
                input logic [2:0] eirq);
    int n;
    wr(FSQ_REG_IRQ_STAT, 32'h7);
    wr(FSQ_REG_CHAN, {22'h0, ch});
    wr(FSQ_REG_CTRL, ctl);
    n = 0;
    d = 32'h1;
    while (d[0] !== 1'b0 && n < 3000)
    begin
      rd(FSQ_REG_STATUS, d);
      n++;
    end
    `CHK("busy", 1'b0, d[0])
    `CHK("chan", ech, tune_chan_out)
    rd(FSQ_REG_IRQ_STAT, d);
    `CHK("irq_stat", eirq, d[2:0])
  endtask : run_seek
  task t_reset;
    `CHK("chan_rst", 10'h000, tune_chan_out)
    rd(FSQ_REG_RSSI_TH, d);
    `CHK("rssi_th", 32'h14, d)
    rd(FSQ_REG_SNR_QT, d);
    `CHK("snr_qt", 32'h00a, d)
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c, d);
    `CHK("unmapped", 32'h0, d)
    wr(FSQ_REG_BAND_HI, 32'h7);
    wr(FSQ_REG_RSSI_QT, 32'h1);
    wr(FSQ_REG_SNR_QT, 32'h1);
    wr(FSQ_REG_RSSI_TH, 32'h14);
    wr(FSQ_REG_IRQ_MASK, 32'h0);
    rd(FSQ_REG_RSSI_QT, d);
    `CHK("rssi_qt", 32'h1, d)
  endtask : t_reset
  task t_up;
    int r0;
    r0 = n_req;
    run_seek(10'h0, 32'h3, 10'h3, 3'h3);
    `CHK("retunes", 3, n_req - r0)
    rd(FSQ_REG_METRICS, d);
    `CHK("metrics", 24'h021e28, d[23:0])
    `CHK("irq_masked", 1'b0, irq_out)
    wr(FSQ_REG_IRQ_MASK, 32'h7);
    @(posedge sys_clk_in);
    `CHK("irq_on", 1'b1, irq_out)
    wr(FSQ_REG_IRQ_STAT, 32'h7);
    @(posedge sys_clk_in);
    `CHK("irq_clr", 1'b0, irq_out)
    wr(FSQ_REG_IRQ_MASK, 32'h0);
  endtask : t_up
  task t_down_ofs_wrap;
    run_seek(10'h6, 32'h1, 10'h4, 3'h3);
    run_seek(10'h3, 32'h13, 10'h7, 3'h5);
    run_seek(10'h7, 32'h17, 10'h3, 3'h3);
  endtask : t_down_ofs_wrap
  task t_ddet;
    int r0;
    run_seek(10'h0, 32'hb, 10'h4, 3'h3);
    rd(FSQ_REG_STATUS, d);
    `CHK("digital", 3'h7, d[3:1])
    r0 = n_req;
    run_seek(10'h4, 32'h28, 10'h4, 3'h3);
    `CHK("tune_retunes", 1, n_req - r0)
  endtask : t_ddet
  initial
  begin
    repeat (5) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_up();
    t_down_ofs_wrap();
    t_ddet();
    summarize();
  end
endmodule : fsq_seek_test
